// *** src/svm_pkg.sv ***
// constants, layouts and types of the supply voltage monitor
package svm_pkg;

   // -----------------------------------------------------------------
   // bus and register map
   // -----------------------------------------------------------------
   localparam int unsigned SVM_DATA_W      = 32;
   localparam int unsigned SVM_ADDR_W      = 8;
   localparam logic [7:0]  SVM_OFF_CTRL    = 8'h00;
   localparam logic [7:0]  SVM_OFF_STATUS  = 8'h04;
   localparam logic [7:0]  SVM_OFF_MASK    = 8'h08;
   localparam logic [1:0]  SVM_HTRANS_NSEQ = 2'h2;
   localparam logic        SVM_HRESP_OKAY  = 1'h0;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int unsigned SVM_THR_LSB     = 0;
   localparam int unsigned SVM_THR_W       = 3;
   localparam int unsigned SVM_EN_BIT      = 4;
   localparam int unsigned SVM_UVF_BIT     = 5;
   localparam int unsigned SVM_IRQF_BIT    = 0;
   localparam int unsigned SVM_SETTLED_BIT = 1;
   localparam int unsigned SVM_MASK_BIT    = 0;
   localparam int unsigned SVM_MV_W        = 13;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [2:0]  SVM_THR_RST     = 3'h0;
   localparam logic        SVM_EN_RST      = 1'h0;
   localparam logic        SVM_MASK_RST    = 1'h0;
   localparam logic [12:0] SVM_MV_RST      = 13'h0708;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int unsigned SVM_CLK_MHZ       = 25;
   localparam int unsigned SVM_IRQ_DELAY_NS  = 1000;
   localparam int unsigned SVM_SETTLE_NS     = 2000;
   localparam int unsigned SVM_IRQ_DELAY_CYC =
      (SVM_IRQ_DELAY_NS * SVM_CLK_MHZ + 999) / 1000;
   localparam int unsigned SVM_SETTLE_CYC    =
      (SVM_SETTLE_NS * SVM_CLK_MHZ + 999) / 1000;
   localparam int unsigned SVM_CNT_W         = 12;

   // -----------------------------------------------------------------
   // delay sequencer states, gray along wait-count-done
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SVM_D_WAIT  = 2'h0,
      SVM_D_COUNT = 2'h1,
      SVM_D_DONE  = 2'h3
   } svm_dly_state_t;

   // -----------------------------------------------------------------
   // threshold code to millivolts
   // -----------------------------------------------------------------
   function automatic logic [12:0] svm_thr_mv(input logic [2:0] code);
      logic [12:0] mv;
      mv = SVM_MV_RST;
      case (code)
         3'h0:    mv = 13'h0708; // 1.8 v
         3'h1:    mv = 13'h07D0; // 2.0 v
         3'h2:    mv = 13'h0960; // 2.4 v
         3'h3:    mv = 13'h0A8C; // 2.7 v
         3'h4:    mv = 13'h0BB8; // 3.0 v
         3'h5:    mv = 13'h0CE4; // 3.3 v
         3'h6:    mv = 13'h0E10; // 3.6 v
         default: mv = 13'h0FA0; // 4.0 v
      endcase
      return mv;
   endfunction

endpackage

// *** src/svm_sync2.sv ***
// two flip-flop level synchroniser
module svm_sync2 (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic async_in,
   output logic      sync_out
);

   // -----------------------------------------------------------------
   // stages
   // -----------------------------------------------------------------
   logic stage1_ff;
   logic stage2_ff;

   // first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stage1_ff <= 1'h0;
         stage2_ff <= 1'h0;
      end else begin
         stage1_ff <= async_in;
         stage2_ff <= stage1_ff;
      end
   end

   assign sync_out = stage2_ff;

endmodule // svm_sync2

// *** src/svm_top.sv ***
// supply voltage monitor control and status logic with ahb-lite slave
//
// Operation
// - a three-bit threshold select picks one of eight levels from 1.8 v (000) to 4.0 v (111).
// - the undervoltage status flag is high while the supply is below the selected level, low otherwise.
// - writing the monitor enable bit to one turns the detector on, writing zero turns it off.
// - the detector stays off during sleep even with the monitor enable bit set.
// - the status flag may toggle repeatedly near the threshold and the logic copes with that.
// - the interrupt request flag sets only once the interrupt delay has passed after the status flag rose; writing one to the flag sets it at once.
// - a new interrupt request wakes the core out of idle; only a detector set while the flag is clear gives the wake.
// - control bits 7, 6 and 3 read zero, the status flag is read-only and other bits read-write.
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
module svm_top
   import svm_pkg::*;
#(
   parameter int unsigned IRQ_DELAY_CYCLES = SVM_IRQ_DELAY_CYC,
   parameter int unsigned SETTLE_CYCLES    = SVM_SETTLE_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        comparator_raw,
   input  wire logic        sleep_mode,
   input  wire logic        idle_mode,
   output logic             detector_enable,
   output logic      [2:0]  threshold_code,
   output logic      [12:0] threshold_mv,
   output logic             irq,
   output logic             wake_request
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   localparam logic [SVM_CNT_W-1:0] DLY_LAST =
      SVM_CNT_W'(IRQ_DELAY_CYCLES - 1);
   localparam logic [SVM_CNT_W-1:0] SETTLE_END =
      SVM_CNT_W'(SETTLE_CYCLES);

   logic                  comp_sync;
   logic                  accept;
   logic                  rd_accept;
   logic                  wr_ctrl;
   logic                  wr_status;
   logic                  wr_mask;
   logic                  rd_clr_status;
   logic                  hw_set;
   logic                  sw_set;
   logic [SVM_ADDR_W-1:0] addr_word;

   logic                  wr_pend_ff;
   logic [SVM_ADDR_W-1:0] wr_addr_ff;
   logic [31:0]           hrdata_ff;
   logic [2:0]            thr_ff;
   logic                  mon_en_ff;
   logic                  mask_ff;
   logic                  det_on_ff;
   logic                  uv_flag_ff;
   logic [SVM_CNT_W-1:0]  settle_cnt_ff;
   logic                  settled_ff;
   svm_dly_state_t        dly_state_ff;
   svm_dly_state_t        nxt_dly_state;
   logic [SVM_CNT_W-1:0]  dly_cnt_ff;
   logic [SVM_CNT_W-1:0]  nxt_dly_cnt;
   logic                  irq_flag_ff;
   logic                  nxt_irq_flag;
   logic                  wake_ff;
   logic [12:0]           mv_ff;

   // -----------------------------------------------------------------
   // comparator input crossing
   // -----------------------------------------------------------------

   // two flops before the comparator level is looked at
   svm_sync2 u_comp_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (comparator_raw),
      .sync_out (comp_sync)
   );

   // -----------------------------------------------------------------
   // ahb-lite address phase decode
   // -----------------------------------------------------------------

   // zero wait states, always okay
   assign hreadyout = 1'h1;
   assign hresp     = SVM_HRESP_OKAY;
   assign hrdata    = hrdata_ff;

   // transfer accepted on nonseq with hready
   assign addr_word = haddr[SVM_ADDR_W-1:0];
   assign accept    = hsel & hready & (htrans == SVM_HTRANS_NSEQ);
   assign rd_accept = accept & ~hwrite;

   // status read clears the sticky flag at the address phase
   assign rd_clr_status = rd_accept & (addr_word == SVM_OFF_STATUS);

   // data phase write strobes
   assign wr_ctrl   = wr_pend_ff & (wr_addr_ff == SVM_OFF_CTRL);
   assign wr_status = wr_pend_ff & (wr_addr_ff == SVM_OFF_STATUS);
   assign wr_mask   = wr_pend_ff & (wr_addr_ff == SVM_OFF_MASK);

   // writing one to the flag sets it, zero does nothing
   assign sw_set = wr_status & hwdata[SVM_IRQF_BIT];

   // write pending, captured for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'h0;
         wr_addr_ff <= '0;
      end else begin
         wr_pend_ff <= accept & hwrite;
         if (accept) begin
            wr_addr_ff <= addr_word;
         end
      end
   end

   // -----------------------------------------------------------------
   // read data
   // -----------------------------------------------------------------

   // read value sampled at the address phase, unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= '0;
      end else if (rd_accept) begin
         hrdata_ff <= '0;
         case (addr_word)
            SVM_OFF_CTRL: begin
               hrdata_ff[SVM_THR_LSB +: SVM_THR_W] <= thr_ff;
               hrdata_ff[SVM_EN_BIT]               <= mon_en_ff;
               hrdata_ff[SVM_UVF_BIT]              <= uv_flag_ff;
            end
            SVM_OFF_STATUS: begin
               hrdata_ff[SVM_IRQF_BIT]    <= irq_flag_ff;
               hrdata_ff[SVM_SETTLED_BIT] <= settled_ff;
            end
            SVM_OFF_MASK: begin
               hrdata_ff[SVM_MASK_BIT] <= mask_ff;
            end
            default: begin
               hrdata_ff <= '0;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // control register
   // -----------------------------------------------------------------

   // threshold and enable, status flag bit is not writable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         thr_ff    <= SVM_THR_RST;
         mon_en_ff <= SVM_EN_RST;
      end else if (wr_ctrl) begin
         thr_ff    <= hwdata[SVM_THR_LSB +: SVM_THR_W];
         mon_en_ff <= hwdata[SVM_EN_BIT];
      end
   end

   // mask register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_ff <= SVM_MASK_RST;
      end else if (wr_mask) begin
         mask_ff <= hwdata[SVM_MASK_BIT];
      end
   end

   // -----------------------------------------------------------------
   // detector power and threshold
   // -----------------------------------------------------------------

   // detector runs only when enabled and not asleep
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         det_on_ff <= 1'h0;
      end else begin
         det_on_ff <= mon_en_ff & ~sleep_mode;
      end
   end

   // level code to the analog side and its value in millivolts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mv_ff <= SVM_MV_RST;
      end else begin
         mv_ff <= svm_thr_mv(thr_ff);
      end
   end

   assign detector_enable = det_on_ff;
   assign threshold_code  = thr_ff;
   assign threshold_mv    = mv_ff;

   // -----------------------------------------------------------------
   // settling tracker
   // -----------------------------------------------------------------

   // counts from detector turn-on, shows when the flag is trustworthy
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         settle_cnt_ff <= '0;
         settled_ff    <= 1'h0;
      end else if (!det_on_ff) begin
         settle_cnt_ff <= '0;
         settled_ff    <= 1'h0;
      end else if (settle_cnt_ff != SETTLE_END) begin
         settle_cnt_ff <= settle_cnt_ff + 1'h1;
         settled_ff    <= 1'h0;
      end else begin
         settled_ff    <= 1'h1;
      end
   end

   // -----------------------------------------------------------------
   // undervoltage status flag
   // -----------------------------------------------------------------

   // follows the synced comparator, forced low with the detector off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         uv_flag_ff <= 1'h0;
      end else begin
         uv_flag_ff <= det_on_ff & comp_sync;
      end
   end

   // -----------------------------------------------------------------
   // interrupt delay sequencer
   // -----------------------------------------------------------------

   // restarts whenever the flag drops, so chatter never fires early
   always_comb begin
      nxt_dly_state = dly_state_ff;
      nxt_dly_cnt   = dly_cnt_ff;
      hw_set        = 1'h0;
      case (dly_state_ff)
         SVM_D_WAIT: begin
            nxt_dly_cnt = '0;
            if (uv_flag_ff) begin
               nxt_dly_state = SVM_D_COUNT;
            end
         end
         SVM_D_COUNT: begin
            if (!uv_flag_ff) begin
               nxt_dly_state = SVM_D_WAIT;
               nxt_dly_cnt   = '0;
            end else if (dly_cnt_ff == DLY_LAST) begin
               nxt_dly_state = SVM_D_DONE;
               hw_set        = 1'h1;
            end else begin
               nxt_dly_cnt = dly_cnt_ff + 1'h1;
            end
         end
         SVM_D_DONE: begin
            nxt_dly_cnt = '0;
            if (!uv_flag_ff) begin
               nxt_dly_state = SVM_D_WAIT;
            end
         end
         default: begin
            nxt_dly_state = SVM_D_WAIT;
            nxt_dly_cnt   = '0;
         end
      endcase
   end

   // sequencer state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dly_state_ff <= SVM_D_WAIT;
         dly_cnt_ff   <= '0;
      end else begin
         dly_state_ff <= nxt_dly_state;
         dly_cnt_ff   <= nxt_dly_cnt;
      end
   end

   // -----------------------------------------------------------------
   // interrupt request flag and output
   // -----------------------------------------------------------------

   // sticky, read clears, any set in the same cycle wins
   always_comb begin
      nxt_irq_flag = irq_flag_ff & ~rd_clr_status;
      if (hw_set || sw_set) begin
         nxt_irq_flag = 1'h1;
      end
   end

   // request flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_flag_ff <= 1'h0;
      end else begin
         irq_flag_ff <= nxt_irq_flag;
      end
   end

   // level interrupt while unmasked flag is set
   assign irq = irq_flag_ff & mask_ff;

   // -----------------------------------------------------------------
   // idle wake-up
   // -----------------------------------------------------------------

   // one pulse on a fresh request while idle, a preset flag blocks it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_ff <= 1'h0;
      end else begin
         wake_ff <= hw_set & ~irq_flag_ff & idle_mode;
      end
   end

   assign wake_request = wake_ff;

endmodule // svm_top

// *** verification/svm_top_chk.sv ***
// concurrent port checks for the supply voltage monitor
module svm_top_chk
   import svm_pkg::*;
#(
   parameter int unsigned IRQ_DELAY_CYCLES = 3,
   parameter int unsigned SETTLE_CYCLES    = 4
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        comparator_raw,
   input wire logic        sleep_mode,
   input wire logic        idle_mode,
   input wire logic        detector_enable,
   input wire logic [2:0]  threshold_code,
   input wire logic [12:0] threshold_mv,
   input wire logic        irq,
   input wire logic        wake_request
);
   localparam logic [12:0] MV_TAB [8] = '{13'h0708, 13'h07D0, 13'h0960, 13'h0A8C,
                                         13'h0BB8, 13'h0CE4, 13'h0E10, 13'h0FA0};
   // -----------------------------------------------------------------
   // helper logic
   // -----------------------------------------------------------------
   logic        tkn;
   logic        wr_dph_ff;
   logic [11:0] run_ff;
   logic [11:0] nxt_run;
   // transfer accepted this edge
   assign tkn = hsel && hready && htrans == SVM_HTRANS_NSEQ;
   assign nxt_run = (comparator_raw && detector_enable) ? run_ff + ((&run_ff) ? 12'h0 : 12'h1) : 12'h0;
   // write data phase marker
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) wr_dph_ff <= 1'b0;
      else          wr_dph_ff <= tkn && hwrite;
   end
   // consecutive cycles the detector reports low supply
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) run_ff <= 12'h0;
      else          run_ff <= nxt_run;
   end
   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   a_thr_table: assert property (threshold_mv == MV_TAB[$past(threshold_code)])
      else $error("threshold millivolts wrong for code");
   a_sleep_off: assert property (sleep_mode |=> !detector_enable) else $error("detector on in sleep");
   a_en_awake: assert property ($rose(detector_enable) |-> !$past(sleep_mode))
      else $error("detector rose during sleep");
   a_wake_one: assert property (wake_request |=> !wake_request) else $error("wake longer than a cycle");
   a_wake_idle: assert property (wake_request |-> $past(idle_mode) || $past(idle_mode, 2))
      else $error("wake without idle");
   a_irq_delay: assert property ($rose(irq) && !$past(wr_dph_ff) |-> run_ff >= 12'(IRQ_DELAY_CYCLES))
      else $error("interrupt before delay");
   a_rdata_hold: assert property (!$past(tkn && !hwrite) |-> $stable(hrdata))
      else $error("read data changed without read");
endmodule // svm_top_chk

// *** verification/svm_top_tb.sv ***
// self-checking testbench for the supply voltage monitor
module svm_top_tb
   import svm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned IRQ_DELAY_CYCLES = 3;
   localparam int unsigned SETTLE_CYCLES    = 4;
   localparam logic [12:0] MV_TAB [8] = '{13'h0708, 13'h07D0, 13'h0960, 13'h0A8C,
                                         13'h0BB8, 13'h0CE4, 13'h0E10, 13'h0FA0};
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, wake_request;
   logic        comparator_raw, sleep_mode, idle_mode, detector_enable;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize, threshold_code;
   logic [12:0] threshold_mv;
   wire         hready = hreadyout;
   int          bad_count, checked, wake_cnt;
   logic [31:0] exp_q [$];
   logic        rd_dph = 1'b0;

   svm_top #(.IRQ_DELAY_CYCLES(IRQ_DELAY_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .comparator_raw(comparator_raw), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
      .detector_enable(detector_enable), .threshold_code(threshold_code), .threshold_mv(threshold_mv),
      .irq(irq), .wake_request(wake_request));

   initial hclk = 1'b0;
   always #20 hclk = ~hclk;

   // -----------------------------------------------------------------
   // checking
   // -----------------------------------------------------------------
   task automatic final_report();
      if (bad_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // read data is taken at the edge that ends the data phase
   always @(posedge hclk) begin
      if (rd_dph && hreadyout === 1'b1) chk("hrdata", exp_q.pop_front(), hrdata);
      rd_dph <= hsel && hreadyout && htrans == SVM_HTRANS_NSEQ && !hwrite;
   end
   // count wake pulses
   always @(posedge hclk) if (wake_request === 1'b1) wake_cnt++;

   // -----------------------------------------------------------------
   // bus master
   // -----------------------------------------------------------------
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         bad_count++;
         final_report();
      end
   endtask
   // one single word transfer, read expects d
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= SVM_HTRANS_NSEQ;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      if (!wr) exp_q.push_back(d);
      wait_rdy();
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   initial begin
      int n;
      {hresetn, hsel, hwrite, comparator_raw, sleep_mode, idle_mode} = 6'h0;
      {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
      {bad_count, checked, wake_cnt} = {32'h0, 32'h0, 32'h0};
      void'($urandom(50));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      bus(SVM_OFF_CTRL, 1'b0, 32'h0);
      bus(SVM_OFF_STATUS, 1'b0, 32'h0);
      bus(SVM_OFF_MASK, 1'b0, 32'h0);
      bus(8'h0C, 1'b1, 32'hFFFFFFFF);
      bus(8'h0C, 1'b0, 32'h0);
      // every threshold code, enable bit held clear, with random junk in the other bits
      for (int i = 0; i < 8; i++) begin
         bus(SVM_OFF_CTRL, 1'b1, ($urandom() & 32'hFFFFFFE8) | 32'(i));
         bus(SVM_OFF_CTRL, 1'b0, 32'(i));
         chk("threshold_mv", 32'(MV_TAB[i]), 32'(threshold_mv));
         chk("threshold_code", 32'(i), 32'(threshold_code));
      end
      // enable, low supply seen, flag and read clear
      bus(SVM_OFF_CTRL, 1'b1, 32'h14);
      comparator_raw <= 1'b1;
      // settling wait before the status flag is trusted
      repeat (12) @(posedge hclk);
      chk("detector_enable", 32'h1, 32'(detector_enable));
      bus(SVM_OFF_CTRL, 1'b0, 32'h34);
      bus(SVM_OFF_STATUS, 1'b0, 32'h3);
      bus(SVM_OFF_STATUS, 1'b0, 32'h2);
      comparator_raw <= 1'b0;
      repeat (6) @(posedge hclk);
      bus(SVM_OFF_CTRL, 1'b0, 32'h14);
      // sleep keeps the detector off
      sleep_mode <= 1'b1;
      comparator_raw <= 1'b1;
      repeat (6) @(posedge hclk);
      chk("detector_enable", 32'h0, 32'(detector_enable));
      bus(SVM_OFF_CTRL, 1'b0, 32'h14);
      bus(SVM_OFF_STATUS, 1'b0, 32'h0);
      sleep_mode <= 1'b0;
      comparator_raw <= 1'b0;
      repeat (12) @(posedge hclk);
      bus(SVM_OFF_MASK, 1'b1, 32'h1);
      bus(SVM_OFF_MASK, 1'b0, 32'h1);
      idle_mode <= 1'b1;
      // bounces one cycle shorter than the delay
      repeat (4) begin
         comparator_raw <= 1'b1;
         repeat (IRQ_DELAY_CYCLES - 1) @(posedge hclk);
         comparator_raw <= 1'b0;
         repeat (3) @(posedge hclk);
      end
      repeat (6) @(posedge hclk);
      chk("irq", 32'h0, 32'(irq));
      comparator_raw <= 1'b1;
      n = 0;
      while (irq !== 1'b1 && n < 60) begin
         @(posedge hclk);
         n++;
      end
      // a spent wait is a mismatch and ends the run
      if (irq !== 1'b1) begin
         bad_count++;
         final_report();
      end
      chk("irq", 32'h1, 32'(irq));
      chk("irq_delay", 32'h1, 32'(n >= IRQ_DELAY_CYCLES));
      repeat (2) @(posedge hclk);
      chk("wake_cnt", 32'h1, 32'(wake_cnt));
      bus(SVM_OFF_STATUS, 1'b0, 32'h3);
      @(posedge hclk);
      chk("irq", 32'h0, 32'(irq));
      comparator_raw <= 1'b0;
      repeat (6) @(posedge hclk);
      // flag set by software suppresses the wake
      bus(SVM_OFF_STATUS, 1'b1, 32'h1);
      @(posedge hclk);
      chk("irq", 32'h1, 32'(irq));
      comparator_raw <= 1'b1;
      repeat (15) @(posedge hclk);
      chk("wake_cnt", 32'h1, 32'(wake_cnt));
      bus(SVM_OFF_STATUS, 1'b0, 32'h3);
      comparator_raw <= 1'b0;
      bus(SVM_OFF_MASK, 1'b1, 32'h0);
      bus(SVM_OFF_STATUS, 1'b1, 32'h1);
      @(posedge hclk);
      chk("irq", 32'h0, 32'(irq));
      bus(SVM_OFF_STATUS, 1'b0, 32'h3);
      idle_mode <= 1'b0;
      repeat (2) @(posedge hclk);
      final_report();
   end
endmodule // svm_top_tb

bind svm_top svm_top_chk #(.IRQ_DELAY_CYCLES(IRQ_DELAY_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .comparator_raw(comparator_raw), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
   .detector_enable(detector_enable), .threshold_code(threshold_code), .threshold_mv(threshold_mv),
   .irq(irq), .wake_request(wake_request));
